// file: hw/scr_pkg.sv
package scr_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  // Remote contacts must be stable this long before they count
  localparam int DEBOUNCE_NS   = 10000;
  // Least time, so round up to whole cycles
  localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] ISTS_OFS  = 8'h08;
  localparam logic [7:0] IMSK_OFS  = 8'h0c;

  // Control register fields
  localparam int CTRL_CO2_FIT_BIT  = 0;
  localparam int CTRL_O2_FIT_BIT   = 1;
  localparam int CTRL_RANGE_LSB    = 2;
  localparam int CTRL_W            = 4;
  localparam int CTRL_CLR_WARN_BIT = 8;
  localparam logic [3:0] CTRL_RST  = 4'h0;

  // Range mode encodings
  localparam logic [1:0] RANGE_SINGLE = 2'h0;
  localparam logic [1:0] RANGE_DUAL   = 2'h1;
  localparam logic [1:0] RANGE_AUTO   = 2'h2;

  // Interrupt status / mask bits
  localparam int IRQ_FAULT_BIT  = 0;
  localparam int IRQ_CONC1_BIT  = 1;
  localparam int IRQ_CONC2_BIT  = 2;
  localparam int IRQ_REMOTE_BIT = 3;
  localparam int IRQ_W          = 4;
  localparam logic [3:0] ISTS_RST = 4'h0;
  localparam logic [3:0] IMSK_RST = 4'h0;

  // Number of remote control inputs
  localparam int REMOTE_N = 3;

  // Remote mode shown in the display mode field
  typedef enum logic [1:0] {
    mode_normal,
    mode_remote_baseline,
    remote_midpoint_display,
    remote_upper_scale_display
  } scr_mode_e;

endpackage

// file: hw/scr_sync2.sv
`timescale 1ns/10ps
module scr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // ****************************************************************
  // Two-stage synchroniser, first stage feeds only the second
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// file: hw/scr_debounce.sv
`timescale 1ns/10ps
module scr_debounce #(
  parameter int CYC = 200,
  parameter int CW  = $clog2(CYC + 1)
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      level_ff
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  wire           differs = raw_in != level_ff;
  wire           settled = cnt_ff == CW'(CYC - 1);

  // Count only while input disagrees; any bounce restarts the count
  assign nxt_cnt = (differs && !settled) ? cnt_ff + CW'(1) : '0;

  // ****************************************************************
  // Accept a new level after CYC stable cycles
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= '0;
      level_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      if (differs && settled) begin
        level_ff <= raw_in;
      end
    end
  end

endmodule

// file: hw/scr_status_relay_io.sv
// How it works
// - health output high exactly when no fault
// - valid output low during hold-off, fault, calibration
// - upper-scale output in high range, dual/auto
// - zero and span flags track calibration phases
// - service-test output follows diagnostic mode
// - sensor calibration outputs only when sensor fitted
// - remote input one gives baseline calibration
// - remote input two gives midpoint span calibration
// - remote input three forces high range, dual/auto
// - health relay energized when healthy, no warnings
// - warning or diagnostic mode drops health relay
// - relay health separate; relays follow alarms, range
// - first alarm relay follows concentration, no latch
// - panel warning latches until button or command
// - range relay on in auto high range
`timescale 1ns/10ps
module scr_status_relay_io #(
  parameter int DEB_CYC = scr_pkg::DEBOUNCE_CYC,
  parameter int AW      = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Internal instrument conditions, same clock
  input  wire logic          fault_any,
  input  wire logic          warning_any,
  input  wire logic          hold_off,
  input  wire logic          high_range_active,
  input  wire logic          zero_cal_active,
  input  wire logic          span_cal_active,
  input  wire logic          diag_active,
  input  wire logic          carbon_dioxide_sensor_calibration_flag_active,
  input  wire logic          oxygen_sensor_calibration_flag_active,
  input  wire logic          conc_over1,
  input  wire logic          conc_over2,
  input  wire logic          panel_clear,
  // Remote control contacts, asynchronous pins
  input  wire logic          remote_zero_pin,
  input  wire logic          remote_span_pin,
  input  wire logic          remote_high_pin,
  // Isolated status outputs
  output logic               status_health_ok,
  output logic               status_meas_valid,
  output logic               status_upper_scale,
  output logic               status_zero_cal,
  output logic               status_span_cal,
  output logic               service_test_flag,
  output logic               carbon_dioxide_sensor_calibration_flag,
  output logic               oxygen_sensor_calibration_flag,
  // Commands to the measurement core
  output logic               remote_zero_req,
  output logic               remote_span_req,
  output logic               force_high_range,
  output logic [1:0]         mode_field,
  output logic               conc_warning,
  // Alarm relays
  output logic               relay_health_energize,
  output logic               relay_conc1,
  output logic               relay_conc2,
  output logic               relay_range,
  output logic               irq
);

  // ****************************************************************
  // Remote input conditioning
  // ****************************************************************
  logic [scr_pkg::REMOTE_N-1:0] rem_sync;
  logic [scr_pkg::REMOTE_N-1:0] rem_deb;
  logic [scr_pkg::REMOTE_N-1:0] rem_prev_ff;

  // Contacts are asynchronous and bouncy
  scr_sync2 #(
    .W (scr_pkg::REMOTE_N)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({remote_high_pin, remote_span_pin, remote_zero_pin}),
    .sync_out (rem_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < scr_pkg::REMOTE_N; gi++) begin : g_deb
      scr_debounce #(
        .CYC (DEB_CYC)
      ) u_deb (
        .pclk     (pclk),
        .presetn  (presetn),
        .raw_in   (rem_sync[gi]),
        .level_ff (rem_deb[gi])
      );
    end
  endgenerate

  wire rem_zero = rem_deb[0];
  wire rem_span = rem_deb[1];
  wire rem_high = rem_deb[2];

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic [scr_pkg::CTRL_W-1:0] ctrl_ff;
  logic [scr_pkg::IRQ_W-1:0]  ists_ff;
  logic [scr_pkg::IRQ_W-1:0]  imsk_ff;
  logic [scr_pkg::IRQ_W-1:0]  nxt_ists;
  logic [31:0]                rd_val;
  logic [31:0]                stat_word;

  // One wait state: pready rises in the second access cycle
  wire acc       = psel & penable;
  wire acc_first = acc & ~pready;
  wire wr_fire   = acc & pready & pwrite;
  wire [7:0] ofs = 8'(paddr);
  wire hit_ctrl  = ofs == scr_pkg::CTRL_OFS;
  wire hit_stat  = ofs == scr_pkg::STAT_OFS;
  wire hit_ists  = ofs == scr_pkg::ISTS_OFS;
  wire hit_imsk  = ofs == scr_pkg::IMSK_OFS;
  wire mapped    = hit_ctrl | hit_stat | hit_ists | hit_imsk;

  // Configuration fields
  wire       co2_fitted = ctrl_ff[scr_pkg::CTRL_CO2_FIT_BIT];
  wire       o2_fitted  = ctrl_ff[scr_pkg::CTRL_O2_FIT_BIT];
  wire [1:0] range_mode = ctrl_ff[scr_pkg::CTRL_RANGE_LSB +: 2];
  wire       range_dual = range_mode == scr_pkg::RANGE_DUAL;
  wire       range_auto = range_mode == scr_pkg::RANGE_AUTO;
  wire       range_multi = range_dual | range_auto;
  // Serial clear of the latched warning is a write-one pulse
  wire       sw_clear = wr_fire & hit_ctrl & pwdata[scr_pkg::CTRL_CLR_WARN_BIT];

  // ****************************************************************
  // Condition logic
  // ****************************************************************
  scr_pkg::scr_mode_e mode_nxt;

  // Zero has priority if a controller closes both contacts
  wire nxt_rzero = rem_zero;
  wire nxt_rspan = rem_span & ~rem_zero;
  // Force is ignored in single range mode
  wire nxt_force = rem_high & range_multi;

  always_comb begin
    mode_nxt = scr_pkg::mode_normal;
    if (nxt_force) begin
      mode_nxt = scr_pkg::remote_upper_scale_display;
    end else if (nxt_rzero) begin
      mode_nxt = scr_pkg::mode_remote_baseline;
    end else if (nxt_rspan) begin
      mode_nxt = scr_pkg::remote_midpoint_display;
    end
  end

  // Calibration phases from the core or from remote contacts
  wire nxt_zcal  = zero_cal_active | nxt_rzero;
  wire nxt_scal  = span_cal_active | nxt_rspan;
  wire nxt_ok    = ~fault_any;
  // Zero or span calibration suppresses the reading as well
  wire nxt_valid = ~hold_off & ~fault_any & ~nxt_zcal & ~nxt_scal;
  wire nxt_upper = range_multi & (high_range_active | nxt_force);
  wire nxt_co2   = co2_fitted & carbon_dioxide_sensor_calibration_flag_active;
  wire nxt_o2    = o2_fitted & oxygen_sensor_calibration_flag_active;

  // Latched panel warning: a new exceedance beats a clear
  wire conc_any  = conc_over1 | conc_over2;
  wire nxt_warn  = conc_any | (conc_warning & ~(panel_clear | sw_clear));

  // Second health signal, independent of the status output
  wire health2   = ~fault_any & ~warning_any & ~conc_warning;
  wire nxt_hrly  = health2 & ~diag_active;
  wire nxt_rrly  = range_auto & high_range_active;

  // ****************************************************************
  // Interrupt events, write one to clear, set wins
  // ****************************************************************
  logic [scr_pkg::IRQ_W-1:0] ev;
  wire [scr_pkg::IRQ_W-1:0]  w1c = (wr_fire & hit_ists) ? pwdata[scr_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    ev = '0;
    ev[scr_pkg::IRQ_FAULT_BIT]  = status_health_ok & ~nxt_ok;
    ev[scr_pkg::IRQ_CONC1_BIT]  = conc_over1 & ~relay_conc1;
    ev[scr_pkg::IRQ_CONC2_BIT]  = conc_over2 & ~relay_conc2;
    ev[scr_pkg::IRQ_REMOTE_BIT] = |(rem_deb ^ rem_prev_ff);
  end

  assign nxt_ists = (ists_ff & ~w1c) | ev;

  // ****************************************************************
  // Read data
  // ****************************************************************
  assign stat_word = {13'h0, ists_ff != '0, conc_warning, mode_field,
                      relay_range, relay_conc2, relay_conc1, relay_health_energize,
                      force_high_range, remote_span_req, remote_zero_req,
                      oxygen_sensor_calibration_flag, carbon_dioxide_sensor_calibration_flag,
                      service_test_flag, status_span_cal, status_zero_cal,
                      status_upper_scale, status_meas_valid, status_health_ok};

  assign rd_val = hit_ctrl ? {28'h0, ctrl_ff} :
                  hit_stat ? stat_word :
                  hit_ists ? {28'h0, ists_ff} :
                  hit_imsk ? {28'h0, imsk_ff} : 32'h0;

  // ****************************************************************
  // Bus and register state
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~mapped;
      prdata  <= (acc_first & ~pwrite) ? rd_val : 32'h0;
    end
  end

  // Writes land at the edge that samples pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= scr_pkg::CTRL_RST;
      imsk_ff <= scr_pkg::IMSK_RST;
      ists_ff <= scr_pkg::ISTS_RST;
      irq     <= 1'b0;
    end else begin
      if (wr_fire & hit_ctrl) begin
        ctrl_ff <= pwdata[scr_pkg::CTRL_W-1:0];
      end
      if (wr_fire & hit_imsk) begin
        imsk_ff <= pwdata[scr_pkg::IRQ_W-1:0];
      end
      ists_ff <= nxt_ists;
      irq     <= |(nxt_ists & (wr_fire & hit_imsk ? pwdata[scr_pkg::IRQ_W-1:0] : imsk_ff));
    end
  end

  // ****************************************************************
  // Status outputs and commands, all registered
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_health_ok   <= 1'b0;
      status_meas_valid  <= 1'b0;
      status_upper_scale <= 1'b0;
      status_zero_cal    <= 1'b0;
      status_span_cal    <= 1'b0;
      service_test_flag  <= 1'b0;
      carbon_dioxide_sensor_calibration_flag <= 1'b0;
      oxygen_sensor_calibration_flag         <= 1'b0;
    end else begin
      status_health_ok   <= nxt_ok;
      status_meas_valid  <= nxt_valid;
      status_upper_scale <= nxt_upper;
      status_zero_cal    <= nxt_zcal;
      status_span_cal    <= nxt_scal;
      service_test_flag  <= diag_active;
      carbon_dioxide_sensor_calibration_flag <= nxt_co2;
      oxygen_sensor_calibration_flag         <= nxt_o2;
    end
  end

  // Level commands follow the contacts, so release ends calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_zero_req  <= 1'b0;
      remote_span_req  <= 1'b0;
      force_high_range <= 1'b0;
      mode_field       <= scr_pkg::mode_normal;
      rem_prev_ff      <= '0;
    end else begin
      remote_zero_req  <= nxt_rzero;
      remote_span_req  <= nxt_rspan;
      force_high_range <= nxt_force;
      mode_field       <= mode_nxt;
      rem_prev_ff      <= rem_deb;
    end
  end

  // Relays start de-energized, as a powered-down instrument would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_health_energize <= 1'b0;
      relay_conc1           <= 1'b0;
      relay_conc2           <= 1'b0;
      relay_range           <= 1'b0;
      conc_warning          <= 1'b0;
    end else begin
      relay_health_energize <= nxt_hrly;
      relay_conc1           <= conc_over1;
      relay_conc2           <= conc_over2;
      relay_range           <= nxt_rrly;
      conc_warning          <= nxt_warn;
    end
  end

endmodule

// file: verif/scr_plc_model.sv
`timescale 1ns/10ps
// ****************************************
// Contact-closure controller model
// ****************************************
module scr_plc_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] cmd,
  output logic            zero_pin,
  output logic            span_pin,
  output logic            high_pin
);
  // Contacts held closed for the whole command, open on release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {high_pin, span_pin, zero_pin} <= 3'h0;
    end else begin
      {high_pin, span_pin, zero_pin} <= cmd;
    end
  end
endmodule

// file: verif/scr_io_props.sv
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module scr_io_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       fault_any,
  input wire logic       warning_any,
  input wire logic       hold_off,
  input wire logic       zero_cal_active,
  input wire logic       span_cal_active,
  input wire logic       diag_active,
  input wire logic       high_range_active,
  input wire logic       conc_over1,
  input wire logic       conc_over2,
  input wire logic       status_health_ok,
  input wire logic       status_meas_valid,
  input wire logic       status_zero_cal,
  input wire logic       status_upper_scale,
  input wire logic       service_test_flag,
  input wire logic       relay_health_energize,
  input wire logic       relay_conc1,
  input wire logic       relay_range,
  input wire logic       remote_zero_req,
  input wire logic       force_high_range,
  input wire logic [1:0] mode_field,
  input wire logic       conc_warning
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs lag a cycle after release, so judge only from the fourth edge
  logic [1:0] up_ff;
  wire        live = (up_ff == 2'h3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_ff <= 2'h0;
    else if (!live) up_ff <= up_ff + 2'h1;
  end
  property p_health; live |-> status_health_ok == !$past(fault_any); endproperty
  a_health: assert property (p_health) else $error("health output off");
  property p_valid; live && $past(hold_off | fault_any | zero_cal_active | span_cal_active) |-> !status_meas_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("valid output during hold");
  property p_zcal; live && $past(zero_cal_active) |-> status_zero_cal; endproperty
  a_zcal: assert property (p_zcal) else $error("zero flag missing");
  property p_svc; live |-> service_test_flag == $past(diag_active); endproperty
  a_svc: assert property (p_svc) else $error("service flag wrong");
  property p_hrel; live && $past(fault_any | warning_any | diag_active) |-> !relay_health_energize; endproperty
  a_hrel: assert property (p_hrel) else $error("health relay held");
  property p_c1; live |-> relay_conc1 == $past(conc_over1); endproperty
  a_c1: assert property (p_c1) else $error("alarm relay one wrong");
  property p_warn; live && $past(conc_over1 | conc_over2) |-> conc_warning; endproperty
  a_warn: assert property (p_warn) else $error("warning not latched");
  property p_rng; relay_range |-> status_upper_scale && $past(high_range_active); endproperty
  a_rng: assert property (p_rng) else $error("range relay wrong");
  property p_mode; remote_zero_req && !force_high_range |-> mode_field == 2'h1; endproperty
  a_mode: assert property (p_mode) else $error("baseline mode not shown");
  c_zero: cover property (remote_zero_req);
  c_force: cover property (force_high_range && mode_field == 2'h3);
  c_latch: cover property (conc_warning && !relay_conc1);
endmodule
bind scr_status_relay_io scr_io_props u_props (.pclk, .presetn, .fault_any, .warning_any, .hold_off,
  .zero_cal_active, .span_cal_active, .diag_active, .high_range_active, .conc_over1, .conc_over2,
  .status_health_ok, .status_meas_valid, .status_zero_cal, .status_upper_scale, .service_test_flag,
  .relay_health_energize, .relay_conc1, .relay_range, .remote_zero_req, .force_high_range, .mode_field,
  .conc_warning);

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        fault_any, warning_any, hold_off, high_range_active, zero_cal_active, span_cal_active;
  logic        diag_active, carbon_dioxide_sensor_calibration_flag_active, oxygen_sensor_calibration_flag_active, conc_over1, conc_over2, panel_clear;
  logic        remote_zero_pin, remote_span_pin, remote_high_pin, status_health_ok, status_meas_valid;
  logic        status_upper_scale, status_zero_cal, status_span_cal, service_test_flag;
  logic        carbon_dioxide_sensor_calibration_flag, oxygen_sensor_calibration_flag, remote_zero_req;
  logic        remote_span_req, force_high_range, conc_warning, relay_health_energize;
  logic        relay_conc1, relay_conc2, relay_range;
  logic [1:0]  mode_field, m;
  logic [2:0]  cmd;
  int          n_mismatch, check_count;
  scr_status_relay_io #(.DEB_CYC(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fault_any, .warning_any, .hold_off, .high_range_active, .zero_cal_active,
    .span_cal_active, .diag_active, .carbon_dioxide_sensor_calibration_flag_active, .oxygen_sensor_calibration_flag_active, .conc_over1, .conc_over2, .panel_clear,
    .remote_zero_pin, .remote_span_pin, .remote_high_pin, .status_health_ok, .status_meas_valid,
    .status_upper_scale, .status_zero_cal, .status_span_cal, .service_test_flag,
    .carbon_dioxide_sensor_calibration_flag, .oxygen_sensor_calibration_flag, .remote_zero_req,
    .remote_span_req, .force_high_range, .mode_field, .conc_warning, .relay_health_energize, .relay_conc1,
    .relay_conc2, .relay_range, .irq);
  scr_plc_model u_plc (.pclk, .presetn, .cmd, .zero_pin(remote_zero_pin), .span_pin(remote_span_pin),
    .high_pin(remote_high_pin));
  // ****************************************
  // Clock, helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; only the watchdog ends a wait for pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    n_mismatch++;
    print_verdict;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd, panel_clear} <= '0;
    {fault_any, warning_any, hold_off, high_range_active, zero_cal_active, span_cal_active} <= '0;
    {diag_active, carbon_dioxide_sensor_calibration_flag_active, oxygen_sensor_calibration_flag_active, conc_over1, conc_over2} <= '0;
    presetn <= 1'b0;
    step(10);
    presetn <= 1'b1;
    step(2);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h803);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    chk(relay_health_energize, 1'b1);
    chk(status_health_ok, 1'b1);
    chk(status_meas_valid, 1'b1);
    warning_any <= 1'b1;
    step(2);
    chk(relay_health_energize, 1'b0);
    chk(status_health_ok, 1'b1);
    warning_any <= 1'b0;
    fault_any   <= 1'b1;
    step(2);
    chk(status_health_ok, 1'b0);
    chk(status_meas_valid, 1'b0);
    // Hold-off alone must drop the valid output
    fault_any <= 1'b0;
    hold_off  <= 1'b1;
    step(2);
    chk(status_meas_valid, 1'b0);
    chk(status_health_ok, 1'b1);
    hold_off    <= 1'b0;
    diag_active <= 1'b1;
    step(2);
    chk(service_test_flag, 1'b1);
    chk(relay_health_energize, 1'b0);
    chk(status_meas_valid, 1'b1);
    diag_active     <= 1'b0;
    zero_cal_active <= 1'b1;
    step(2);
    chk(status_zero_cal, 1'b1);
    chk(status_meas_valid, 1'b0);
    zero_cal_active <= 1'b0;
    span_cal_active <= 1'b1;
    step(2);
    chk(status_span_cal, 1'b1);
    chk(status_zero_cal, 1'b0);
    span_cal_active <= 1'b0;
    carbon_dioxide_sensor_calibration_flag_active  <= 1'b1;
    oxygen_sensor_calibration_flag_active   <= 1'b1;
    step(2);
    chk({carbon_dioxide_sensor_calibration_flag, oxygen_sensor_calibration_flag}, 2'h0);
    apb(1'b1, 8'h00, 32'h3);
    step(2);
    chk({carbon_dioxide_sensor_calibration_flag, oxygen_sensor_calibration_flag}, 2'h3);
    high_range_active <= 1'b1;
    // Every range mode encoding, including the spare one
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      apb(1'b1, 8'h00, {28'h0, m, 2'h0});
      step(2);
      chk(status_upper_scale, m == scr_pkg::RANGE_DUAL || m == scr_pkg::RANGE_AUTO);
      chk(relay_range, m == scr_pkg::RANGE_AUTO);
    end
    high_range_active <= 1'b0;
    apb(1'b1, 8'h08, 32'hf);
    apb(1'b1, 8'h0c, 32'h2);
    conc_over1 <= 1'b1;
    step(3);
    chk(relay_conc1, 1'b1);
    chk(irq, 1'b1);
    conc_over1 <= 1'b0;
    step(2);
    chk(relay_conc1, 1'b0);
    chk(conc_warning, 1'b1);
    chk(relay_health_energize, 1'b0);
    panel_clear <= 1'b1;
    step(1);
    panel_clear <= 1'b0;
    step(2);
    chk(conc_warning, 1'b0);
    rd(8'h08, 32'h2);
    apb(1'b1, 8'h08, 32'h2);
    step(2);
    chk(irq, 1'b0);
    conc_over2 <= 1'b1;
    step(3);
    chk(relay_conc2, 1'b1);
    chk(irq, 1'b0);
    conc_over2 <= 1'b0;
    apb(1'b1, 8'h00, 32'h104);
    step(2);
    chk(conc_warning, 1'b0);
    rd(8'h08, 32'h4);
    // A two-cycle bounce on the zero contact must not be taken
    cmd <= 3'h1;
    step(2);
    cmd <= 3'h0;
    step(12);
    chk(remote_zero_req, 1'b0);
    cmd <= 3'h1;
    step(4);
    chk(remote_zero_req, 1'b0);
    step(8);
    chk(remote_zero_req, 1'b1);
    chk(mode_field, 2'h1);
    chk(status_zero_cal, 1'b1);
    cmd <= 3'h2;
    step(12);
    chk(remote_span_req, 1'b1);
    chk(remote_zero_req, 1'b0);
    chk(mode_field, 2'h2);
    chk(status_span_cal, 1'b1);
    cmd <= 3'h4;
    step(12);
    chk(force_high_range, 1'b1);
    chk(mode_field, 2'h3);
    chk(status_upper_scale, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    step(3);
    chk(force_high_range, 1'b0);
    chk(mode_field, 2'h0);
    // Both contacts closed: zero wins, and release ends calibration
    cmd <= 3'h3;
    step(12);
    chk(remote_zero_req, 1'b1);
    chk(remote_span_req, 1'b0);
    chk(mode_field, 2'h1);
    cmd <= 3'h0;
    step(12);
    chk(remote_zero_req, 1'b0);
    chk(status_zero_cal, 1'b0);
    chk(mode_field, 2'h0);
    // Reset in mid-run drops the relay and clears event and mask registers
    presetn <= 1'b0;
    step(1);
    chk(status_health_ok, 1'b0);
    chk(relay_health_energize, 1'b0);
    step(1);
    presetn <= 1'b1;
    step(2);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h803);
    print_verdict;
  end
endmodule
